//--- logic/motor_cfg.svh
`ifndef MOTOR_CFG_SVH
`define MOTOR_CFG_SVH
`define CLK_HZ 10000000
`define CLK_NS 100
`define LINK_BAUD 9600
`define BAUD_DIV (((`CLK_HZ) + (`LINK_BAUD) / 2) / (`LINK_BAUD))
`define US_NS 1000
`define US_DIV ((`US_NS) / (`CLK_NS))
`define MS_CYCLES ((`CLK_HZ) / 1000)
`define AUTOSTOP_MS 3000
`define BLINK_MS 250
`define BLINK_DONE 3'h4
`define LAST_BIT 3'h7
`define FRAME_BITS 4'h9
`define WR_GROUP 4'h8
`define WR_LAST 4'h9
`define WR_HOLE 4'h1
`define SET_COUNT 10
`define SET_SPEED 4'h0
`define SET_CUR 4'h2
`define SET_REGEN 4'h3
`define SET_UP 4'h4
`define SET_DOWN 4'h5
`define SET_UV_OFF 4'h6
`define SET_UV_ON 4'h7
`define SET_OV_ON 4'h8
`define SET_OV_OFF 4'h9
`define CMD_SPEED 8'h80
`define CMD_DIR 8'h8A
`define CMD_PERSIST_L 8'hA0
`define CMD_PERSIST_H 8'hA1
`define CMD_MODE_AUTO 8'hE0
`define CMD_MODE_FREE 8'hE1
`define CMD_MODE_OFF 8'hE2
`define RD_GROUP 4'hC
`define RD_CURRENT 8'hCA
`define RD_SUPPLY 8'hCC
`define RD_DEMAND 8'hCD
`define RD_COOLER 8'hCE
`define RD_BOARD 8'hCF
`define RD_FLAGS 8'hD0
`define DIR_STOP 2'h0
`define DIR_FWD 2'h1
`define DIR_REGEN 2'h3
`define BRAKE_ON_LEVEL 7'h04
`define RC_ZERO_US 14'h05DC
`define RC_FULL_US 14'h09C4
`define RC_GAIN 8'h7E
`define RC_SHIFT 10
`define RC_FULL_DUTY 7'h7B
`define DIV_STEPS 3'h7
`define HREG_TX 2'h0
`define HREG_STAT 2'h1
`define HREG_RX 2'h2
`endif

//--- logic/motor_pkg.sv
package motor_pkg;
  typedef enum logic [1:0] {
    SRC_THROTTLE = 2'b00,
    SRC_POT = 2'b01,
    SRC_PWM = 2'b10,
    SRC_RC = 2'b11
  } speed_src_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;
endpackage

//--- logic/motor_link_if.sv
`timescale 1ns/1ns
interface motor_link_if;
  logic host_to_dev;
  logic dev_to_host;
  modport host (output host_to_dev, input dev_to_host);
  modport dev (input host_to_dev, output dev_to_host);
endinterface

//--- logic/motor_ctrl_dev.sv
// How it works
// R01: link runs at 9600 baud
// R02: frames are start, eight data, stop
// R03: host sends command then one 7-bit data
// R04: decode write codes 0x80, 0x82 to 0x89
// R05: read request answered by one data byte
// R06: serve read codes 0xC0 to 0xD0 (0xC1 and 0xCB get no reply)
// R07: direction 0x00 stop, 0x01 forward, 0x03 regen
// R08: 0xE0 autostop mode, 0xE1 plain, 0xE2 exit
// R09: 0xA0/0xA1 store saving bits, no persistence
// R10: output enabled only while enable pulled low
// R11: switches 1 and 2 pick speed source
// R12: switch 3 gates peak current
// R13: switch 4 picks simple serial protocol
// R14: switch 5 on: auto regen below demand
// R15: switch 5 off: brake above 0.15 V
// R16: pulse width measured in 1 us steps
// R17: radio pulse 1.5 ms to 0, 2.5 ms to 97%
// R18: no start while current ceiling is zero
// R19: LED blinks twice after power-up
// R20: LED lights on faults or serial activity
// R21: unknown command bytes ignored, no reply
`timescale 1ns/1ns
`include "motor_cfg.svh"
module motor_ctrl_dev #(
  parameter int AUTOSTOP_CYCLES = `AUTOSTOP_MS * `MS_CYCLES,
  parameter int BLINK_CYCLES = `BLINK_MS * `MS_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // serial link
  motor_link_if.dev link,
  // pins from the board
  input wire logic [4:0] sw_in,
  input wire logic enable_n_in,
  input wire logic pwm_in,
  // sampled analog and status, same clock
  input wire logic [6:0] speed_adc_in,
  input wire logic [6:0] brake_adc_in,
  input wire logic [6:0] motor_speed_in,
  input wire logic [6:0] motor_current_in,
  input wire logic [6:0] supply_level_in,
  input wire logic [6:0] cooler_temp_in,
  input wire logic [6:0] board_temp_in,
  input wire logic over_temp_in,
  input wire logic current_limiting_in,
  input wire logic [6:0] current_ceiling_pot_in,
  input wire logic [6:0] ramp_time_pot_in,
  input wire logic [6:0] braking_ceiling_pot_in,
  // power stage controls
  output logic drive_en_out,
  output logic [6:0] speed_demand_out,
  output logic [1:0] rotation_out,
  output logic brake_active_out,
  output logic [6:0] brake_force_out,
  output logic [6:0] current_ceiling_out,
  output logic [6:0] ramp_up_out,
  output logic [6:0] ramp_down_out,
  output logic peak_current_en_out,
  output logic simple_proto_out,
  output logic serial_mode_out,
  output motor_pkg::speed_src_t speed_source_out,
  output logic [13:0] persist_flags_out,
  output logic led_out
);
  localparam logic [10:0] BAUD_DIV1 = 11'(`BAUD_DIV - 1); // R01
  localparam logic [10:0] BAUD_HALF = 11'(`BAUD_DIV / 2 - 1);
  localparam logic [3:0] US_DIV1 = 4'(`US_DIV - 1);
  localparam logic [24:0] STOP_LAST = 25'(AUTOSTOP_CYCLES - 1);
  localparam logic [21:0] BLINK_LAST = 22'(BLINK_CYCLES - 1);

  function automatic logic is_write(input logic [7:0] c);
    is_write = (c[7:4] == `WR_GROUP && c[3:0] <= `WR_LAST && c[3:0] != `WR_HOLE)
      || c == `CMD_DIR || c == `CMD_PERSIST_L || c == `CMD_PERSIST_H; // R04 R09
  endfunction

  function automatic logic [6:0] rc_scale(input logic [13:0] w);
    logic [16:0] p;
    p = 17'(w - `RC_ZERO_US) * 17'(`RC_GAIN);
    if (w <= `RC_ZERO_US)
      rc_scale = 7'h00;
    else if (w >= `RC_FULL_US)
      rc_scale = `RC_FULL_DUTY;
    else
      rc_scale = 7'(p >> `RC_SHIFT); // R17
  endfunction

  logic rx_m_q, rx_s_q, en_m_q, en_s_q, pwm_m_q, pwm_s_q, pwm_p_q;
  logic [4:0] sw_m_q, sw_s_q;
  always_ff @(posedge ref_clk_in)
  begin
    rx_m_q <= link.host_to_dev;
    rx_s_q <= rx_m_q;
    en_m_q <= enable_n_in;
    en_s_q <= en_m_q;
    pwm_m_q <= pwm_in;
    pwm_s_q <= pwm_m_q;
    pwm_p_q <= pwm_s_q;
    sw_m_q <= sw_in;
    sw_s_q <= sw_m_q;
  end

  // receiver: samples each bit at its centre
  motor_pkg::rx_state_t rx_st_q;
  logic [10:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_vld_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      rx_st_q <= motor_pkg::RX_IDLE;
      rx_cnt_q <= 11'h000;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_vld_q <= 1'b0;
    end
    else
    begin
      rx_vld_q <= 1'b0;
      if (rx_cnt_q != 11'h000)
        rx_cnt_q <= rx_cnt_q - 11'h001;
      unique case (rx_st_q)
        motor_pkg::RX_IDLE:
          if (!rx_s_q)
          begin
            rx_st_q <= motor_pkg::RX_START;
            rx_cnt_q <= BAUD_HALF;
          end
        motor_pkg::RX_START:
          if (rx_cnt_q == 11'h000)
          begin
            rx_st_q <= rx_s_q ? motor_pkg::RX_IDLE : motor_pkg::RX_DATA;
            rx_cnt_q <= BAUD_DIV1;
            rx_bit_q <= 3'h0;
          end
        motor_pkg::RX_DATA:
          if (rx_cnt_q == 11'h000)
          begin
            rx_sh_q <= {rx_s_q, rx_sh_q[7:1]}; // R02
            rx_bit_q <= rx_bit_q + 3'h1;
            rx_cnt_q <= BAUD_DIV1;
            if (rx_bit_q == `LAST_BIT)
              rx_st_q <= motor_pkg::RX_STOP;
          end
        motor_pkg::RX_STOP:
          if (rx_cnt_q == 11'h000)
          begin
            rx_st_q <= motor_pkg::RX_IDLE;
            rx_vld_q <= rx_s_q; // R02
          end
      endcase
    end
  end

  // command interpreter; the advanced protocol is not handled here
  logic byte_in, data_hit;
  logic pend_q, serial_q, auto_q, stopped_q, reply_pend_q, tx_busy_q;
  logic [7:0] cmd_q, reply_q;
  logic [6:0] set_q [0:`SET_COUNT-1];
  logic [1:0] dir_q;
  logic [13:0] persist_q;
  logic [6:0] flags;
  logic uv_q, ov_q;
  assign byte_in = rx_vld_q && sw_s_q[3]; // R13
  assign data_hit = byte_in && !rx_sh_q[7] && pend_q; // R03
  assign flags = {stopped_q, auto_q, serial_q, ov_q, uv_q, en_s_q, current_limiting_in};

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      pend_q <= 1'b0;
      cmd_q <= 8'h00;
      dir_q <= `DIR_STOP;
      persist_q <= 14'h0000;
      for (int i = 0; i < `SET_COUNT; i++)
        set_q[i] <= 7'h00;
    end
    else if (byte_in)
    begin
      pend_q <= rx_sh_q[7] && is_write(rx_sh_q); // R21
      if (rx_sh_q[7])
        cmd_q <= rx_sh_q;
      else if (pend_q)
      begin
        if (cmd_q == `CMD_DIR)
        begin
          if (rx_sh_q[6:2] == 5'h00 && rx_sh_q[1:0] != 2'h2)
            dir_q <= rx_sh_q[1:0]; // R07
        end
        else if (cmd_q == `CMD_PERSIST_L)
          persist_q[6:0] <= rx_sh_q[6:0]; // R09
        else if (cmd_q == `CMD_PERSIST_H)
          persist_q[13:7] <= rx_sh_q[6:0]; // R09
        else
          set_q[cmd_q[3:0]] <= rx_sh_q[6:0]; // R04
      end
    end
  end

  // read answers; a reply waits while the transmitter is busy
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      reply_pend_q <= 1'b0;
      reply_q <= 8'h00;
    end
    else
    begin
      if (!tx_busy_q)
        reply_pend_q <= 1'b0;
      if (byte_in && rx_sh_q[7])
      begin
        reply_pend_q <= 1'b1; // R05
        unique case (rx_sh_q)
          `RD_CURRENT: reply_q <= {1'b0, motor_current_in}; // R06
          `RD_SUPPLY: reply_q <= {1'b0, supply_level_in};
          `RD_DEMAND: reply_q <= {1'b0, speed_adc_in};
          `RD_COOLER: reply_q <= {1'b0, cooler_temp_in};
          `RD_BOARD: reply_q <= {1'b0, board_temp_in};
          `RD_FLAGS: reply_q <= {1'b0, flags};
          default:
            if (rx_sh_q[7:4] == `RD_GROUP && rx_sh_q[3:0] <= `WR_LAST
              && rx_sh_q[3:0] != `WR_HOLE)
              reply_q <= {1'b0, set_q[rx_sh_q[3:0]]}; // R06
            else
              reply_pend_q <= !tx_busy_q && reply_pend_q; // R21
        endcase
      end
    end
  end

  logic [8:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [10:0] tx_cnt_q;
  logic tx_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      tx_q <= 1'b1;
      tx_busy_q <= 1'b0;
      tx_sh_q <= 9'h000;
      tx_left_q <= 4'h0;
      tx_cnt_q <= 11'h000;
    end
    else if (!tx_busy_q)
    begin
      if (reply_pend_q)
      begin
        tx_q <= 1'b0; // R02
        tx_sh_q <= {1'b1, reply_q};
        tx_left_q <= `FRAME_BITS;
        tx_cnt_q <= BAUD_DIV1;
        tx_busy_q <= 1'b1;
      end
    end
    else if (tx_cnt_q != 11'h000)
      tx_cnt_q <= tx_cnt_q - 11'h001;
    else if (tx_left_q != 4'h0)
    begin
      tx_q <= tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[8:1]};
      tx_left_q <= tx_left_q - 4'h1;
      tx_cnt_q <= BAUD_DIV1;
    end
    else
      tx_busy_q <= 1'b0;
  end
  assign link.dev_to_host = tx_q;

  // serial mode and autostop watchdog, restarted by each speed write
  logic [24:0] stop_cnt_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      serial_q <= 1'b0;
      auto_q <= 1'b0;
      stopped_q <= 1'b0;
      stop_cnt_q <= 25'h0000000;
    end
    else if ((byte_in && (rx_sh_q == `CMD_MODE_AUTO || rx_sh_q == `CMD_MODE_FREE
      || rx_sh_q == `CMD_MODE_OFF)) || (data_hit && cmd_q == `CMD_SPEED))
    begin
      stop_cnt_q <= 25'h0000000;
      stopped_q <= 1'b0;
      if (rx_sh_q[7])
      begin
        serial_q <= rx_sh_q != `CMD_MODE_OFF; // R08
        auto_q <= rx_sh_q == `CMD_MODE_AUTO;
      end
    end
    else if (serial_q && auto_q && !stopped_q)
    begin
      if (stop_cnt_q == STOP_LAST)
        stopped_q <= 1'b1; // R08
      else
        stop_cnt_q <= stop_cnt_q + 25'h0000001;
    end
  end

  // pulse input timed in microseconds, duty by serial division
  logic [3:0] us_cnt_q;
  logic [13:0] high_acc_q, per_acc_q, width_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      us_cnt_q <= 4'h0;
      high_acc_q <= 14'h0000;
      per_acc_q <= 14'h0000;
      width_q <= 14'h0000;
    end
    else
    begin
      us_cnt_q <= (us_cnt_q == US_DIV1) ? 4'h0 : us_cnt_q + 4'h1;
      if (pwm_s_q && !pwm_p_q)
      begin
        width_q <= high_acc_q;
        high_acc_q <= 14'h0000;
        per_acc_q <= 14'h0000;
      end
      else if (us_cnt_q == US_DIV1 && per_acc_q != 14'h3FFF)
      begin
        per_acc_q <= per_acc_q + 14'h0001; // R16
        if (pwm_s_q)
          high_acc_q <= high_acc_q + 14'h0001;
      end
    end
  end

  logic [14:0] dv_rem_q, dv_sh;
  logic [13:0] dv_den_q;
  logic [6:0] dv_quo_q, duty_q;
  logic [2:0] dv_step_q;
  logic dv_ge;
  assign dv_sh = {dv_rem_q[13:0], 1'b0};
  assign dv_ge = dv_sh >= {1'b0, dv_den_q};
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      dv_rem_q <= 15'h0000;
      dv_den_q <= 14'h0000;
      dv_quo_q <= 7'h00;
      dv_step_q <= 3'h0;
      duty_q <= 7'h00;
    end
    else if (dv_step_q != 3'h0)
    begin
      dv_rem_q <= dv_ge ? dv_sh - {1'b0, dv_den_q} : dv_sh;
      dv_quo_q <= {dv_quo_q[5:0], dv_ge};
      dv_step_q <= dv_step_q - 3'h1;
      if (dv_step_q == 3'h1)
        duty_q <= {dv_quo_q[5:0], dv_ge}; // R16
    end
    else if (pwm_s_q && !pwm_p_q && per_acc_q != 14'h0000)
    begin
      dv_rem_q <= {1'b0, high_acc_q};
      dv_den_q <= per_acc_q;
      dv_step_q <= `DIV_STEPS;
    end
  end

  // supply protection with hysteresis; a zero level disables its check
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      uv_q <= 1'b0;
      ov_q <= 1'b0;
    end
    else
    begin
      if (supply_level_in < set_q[`SET_UV_OFF])
        uv_q <= 1'b1;
      else if (supply_level_in >= set_q[`SET_UV_ON])
        uv_q <= 1'b0;
      if (set_q[`SET_OV_OFF] != 7'h00 && supply_level_in > set_q[`SET_OV_OFF])
        ov_q <= 1'b1;
      else if (supply_level_in <= set_q[`SET_OV_ON])
        ov_q <= 1'b0;
    end
  end

  logic [21:0] blink_cnt_q;
  logic [2:0] blink_ph_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      blink_cnt_q <= 22'h000000;
      blink_ph_q <= 3'h0;
    end
    else if (blink_ph_q != `BLINK_DONE)
    begin
      blink_cnt_q <= (blink_cnt_q == BLINK_LAST) ? 22'h000000 : blink_cnt_q + 22'h000001;
      if (blink_cnt_q == BLINK_LAST)
        blink_ph_q <= blink_ph_q + 3'h1; // R19
    end
  end

  // registered outputs; pots stand in for settings outside serial mode
  logic [6:0] ceil_w, regen_w, demand_w;
  motor_pkg::speed_src_t src_w;
  always_comb
  begin
    src_w = motor_pkg::speed_src_t'({sw_s_q[0], sw_s_q[1]}); // R11
    ceil_w = serial_q ? set_q[`SET_CUR] : current_ceiling_pot_in;
    regen_w = serial_q ? set_q[`SET_REGEN] : braking_ceiling_pot_in;
    unique case (src_w)
      motor_pkg::SRC_PWM: demand_w = duty_q;
      motor_pkg::SRC_RC: demand_w = rc_scale(width_q); // R17
      default: demand_w = speed_adc_in;
    endcase
    if (serial_q)
      demand_w = stopped_q ? 7'h00 : set_q[`SET_SPEED]; // R08
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      drive_en_out <= 1'b0;
      speed_demand_out <= 7'h00;
      rotation_out <= `DIR_STOP;
      brake_active_out <= 1'b0;
      brake_force_out <= 7'h00;
      current_ceiling_out <= 7'h00;
      ramp_up_out <= 7'h00;
      ramp_down_out <= 7'h00;
      peak_current_en_out <= 1'b0;
      simple_proto_out <= 1'b0;
      serial_mode_out <= 1'b0;
      speed_source_out <= motor_pkg::SRC_THROTTLE;
      persist_flags_out <= 14'h0000;
      led_out <= 1'b0;
    end
    else
    begin
      drive_en_out <= !en_s_q && ceil_w != 7'h00 && !uv_q && !ov_q && !over_temp_in
        && !(serial_q && (stopped_q || dir_q == `DIR_STOP)); // R10 R18
      speed_demand_out <= demand_w;
      rotation_out <= serial_q ? dir_q : `DIR_FWD;
      if (serial_q && dir_q == `DIR_REGEN)
      begin
        brake_active_out <= 1'b1; // R07
        brake_force_out <= regen_w;
      end
      else if (sw_s_q[4])
      begin
        brake_active_out <= motor_speed_in < demand_w; // R14
        brake_force_out <= regen_w;
      end
      else
      begin
        brake_active_out <= brake_adc_in > `BRAKE_ON_LEVEL; // R15
        brake_force_out <= (brake_adc_in < regen_w) ? brake_adc_in : regen_w;
      end
      current_ceiling_out <= ceil_w;
      ramp_up_out <= serial_q ? set_q[`SET_UP] : ramp_time_pot_in;
      ramp_down_out <= serial_q ? set_q[`SET_DOWN] : ramp_time_pot_in;
      peak_current_en_out <= sw_s_q[2]; // R12
      simple_proto_out <= sw_s_q[3]; // R13
      serial_mode_out <= serial_q;
      speed_source_out <= src_w;
      persist_flags_out <= persist_q;
      if (blink_ph_q != `BLINK_DONE)
        led_out <= !blink_ph_q[0]; // R19
      else
        led_out <= current_limiting_in || en_s_q || uv_q || ov_q || over_temp_in
          || rx_st_q != motor_pkg::RX_IDLE || tx_busy_q; // R20
    end
  end
endmodule

//--- logic/motor_ctrl_host.sv
`timescale 1ns/1ns
`include "motor_cfg.svh"
module motor_ctrl_host (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // serial link
  motor_link_if.host link,
  // software register port
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out
);
  localparam logic [10:0] BAUD_DIV1 = 11'(`BAUD_DIV - 1); // R01
  localparam logic [10:0] BAUD_HALF = 11'(`BAUD_DIV / 2 - 1);

  logic rx_m_q, rx_s_q;
  always_ff @(posedge ref_clk_in)
  begin
    rx_m_q <= link.dev_to_host;
    rx_s_q <= rx_m_q;
  end

  motor_pkg::rx_state_t rx_st_q;
  logic [10:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q, rx_byte_q;
  logic rx_full_q, tx_busy_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      rx_st_q <= motor_pkg::RX_IDLE;
      rx_cnt_q <= 11'h000;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_byte_q <= 8'h00;
      rx_full_q <= 1'b0;
    end
    else
    begin
      if (rd_in && addr_in == `HREG_RX)
        rx_full_q <= 1'b0;
      if (rx_cnt_q != 11'h000)
        rx_cnt_q <= rx_cnt_q - 11'h001;
      unique case (rx_st_q)
        motor_pkg::RX_IDLE:
          if (!rx_s_q)
          begin
            rx_st_q <= motor_pkg::RX_START;
            rx_cnt_q <= BAUD_HALF;
          end
        motor_pkg::RX_START:
          if (rx_cnt_q == 11'h000)
          begin
            rx_st_q <= rx_s_q ? motor_pkg::RX_IDLE : motor_pkg::RX_DATA;
            rx_cnt_q <= BAUD_DIV1;
            rx_bit_q <= 3'h0;
          end
        motor_pkg::RX_DATA:
          if (rx_cnt_q == 11'h000)
          begin
            rx_sh_q <= {rx_s_q, rx_sh_q[7:1]}; // R02
            rx_bit_q <= rx_bit_q + 3'h1;
            rx_cnt_q <= BAUD_DIV1;
            if (rx_bit_q == `LAST_BIT)
              rx_st_q <= motor_pkg::RX_STOP;
          end
        motor_pkg::RX_STOP:
          if (rx_cnt_q == 11'h000)
          begin
            rx_st_q <= motor_pkg::RX_IDLE;
            if (rx_s_q)
            begin
              rx_byte_q <= rx_sh_q; // R05
              rx_full_q <= 1'b1;
            end
          end
      endcase
    end
  end

  // a byte written while busy is dropped; software polls the busy bit
  logic [8:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [10:0] tx_cnt_q;
  logic tx_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      tx_q <= 1'b1;
      tx_busy_q <= 1'b0;
      tx_sh_q <= 9'h000;
      tx_left_q <= 4'h0;
      tx_cnt_q <= 11'h000;
    end
    else if (!tx_busy_q)
    begin
      if (wr_in && addr_in == `HREG_TX)
      begin
        tx_q <= 1'b0; // R02
        tx_sh_q <= {1'b1, wdata_in}; // R03
        tx_left_q <= `FRAME_BITS;
        tx_cnt_q <= BAUD_DIV1;
        tx_busy_q <= 1'b1;
      end
    end
    else if (tx_cnt_q != 11'h000)
      tx_cnt_q <= tx_cnt_q - 11'h001;
    else if (tx_left_q != 4'h0)
    begin
      tx_q <= tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[8:1]};
      tx_left_q <= tx_left_q - 4'h1;
      tx_cnt_q <= BAUD_DIV1;
    end
    else
      tx_busy_q <= 1'b0;
  end
  assign link.host_to_dev = tx_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      rdata_out <= 8'h00;
    else if (rd_in && addr_in == `HREG_STAT)
      rdata_out <= {6'h00, rx_full_q, tx_busy_q};
    else if (rd_in && addr_in == `HREG_RX)
      rdata_out <= rx_byte_q;
    else
      rdata_out <= 8'h00;
  end
endmodule

//--- verification/motor_link_properties.sv
`timescale 1ns/1ns
`include "motor_cfg.svh"
module motor_link_properties (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // link lines
  input wire logic host_to_dev,
  input wire logic dev_to_host
);
  localparam int BIT = `BAUD_DIV;
  localparam int MID_START = BIT / 2;
  localparam int MID_STOP = 9 * BIT + BIT / 2;
  localparam int REPLY_LATE = MID_STOP + 12;
  // index 0 is host_to_dev, index 1 is dev_to_host
  logic [1:0] line;
  logic [1:0] prev_q;
  int frame_q [2];
  int low_q [2];
  assign line = {dev_to_host, host_to_dev};
  // one process keeps a single driver per array
  always_ff @(posedge ref_clk_in)
  begin
    prev_q <= rst_in ? 2'h3 : line;
    for (int i = 0; i < 2; i++)
    begin
      low_q[i] <= (rst_in || line[i]) ? 0 : low_q[i] + 1;
      if (rst_in)
        frame_q[i] <= 0;
      else if (frame_q[i] == 0 && prev_q[i] && !line[i])
        frame_q[i] <= 1;
      else if (frame_q[i] != 0)
        frame_q[i] <= (frame_q[i] == 10 * BIT - 1) ? 0 : frame_q[i] + 1;
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence dev_frame_start;
    frame_q[1] == 0 && prev_q[1] && !dev_to_host;
  endsequence
  sequence host_stop_seen;
    frame_q[0] >= MID_STOP && frame_q[0] <= REPLY_LATE;
  endsequence
  idle_after_reset_a: assert property ($fell(rst_in) |-> host_to_dev && dev_to_host)
    else $error("link line not idle after reset");
  host_bit_len_a: assert property ($rose(host_to_dev) |-> low_q[0] % BIT == 0)
    else $error("host low run not whole bits");
  dev_bit_len_a: assert property ($rose(dev_to_host) |-> low_q[1] % BIT == 0)
    else $error("device low run not whole bits");
  host_start_low_a: assert property (frame_q[0] == MID_START |-> !host_to_dev)
    else $error("host start bit not low");
  dev_start_low_a: assert property (frame_q[1] == MID_START |-> !dev_to_host)
    else $error("device start bit not low");
  host_stop_high_a: assert property (frame_q[0] == MID_STOP |-> host_to_dev)
    else $error("host stop bit not high");
  dev_stop_high_a: assert property (frame_q[1] == MID_STOP |-> dev_to_host)
    else $error("device stop bit not high");
  reply_after_request_a: assert property (dev_frame_start |-> host_stop_seen)
    else $error("device frame not right after a request");
endmodule

//--- verification/tb_motor_uart_command_interpreter.sv
`timescale 1ns/1ns
`include "motor_cfg.svh"
module tb_motor_uart_command_interpreter;
  localparam int BIT = `BAUD_DIV;
  localparam int STOP_CYC = 60000;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] addr_q = 2'h0;
  logic [7:0] wdata_q = 8'h00;
  logic wr_q = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] rdata;
  logic [4:0] sw_q = 5'h08;
  logic enable_n_q = 1'b1;
  logic [6:0] brake_q = 7'h00;
  logic [6:0] meas_q = 7'h03;
  logic flag_q = 1'b0;
  logic pwm_q = 1'b0;
  logic drive_en, brake_act, peak_en, simple, serial, led;
  logic [6:0] ceiling;
  logic [6:0] demand, brk_force, ramp_up;
  logic [1:0] rot;
  motor_pkg::speed_src_t src;
  logic [7:0] got;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  motor_link_if link ();
  always #50 ref_clk_in = ~ref_clk_in;
  motor_ctrl_host i_motor_ctrl_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link),
    .addr_in(addr_q), .wdata_in(wdata_q), .wr_in(wr_q), .rd_in(rd_q), .rdata_out(rdata));
  motor_ctrl_dev #(.AUTOSTOP_CYCLES(STOP_CYC), .BLINK_CYCLES(50)) i_motor_ctrl_dev (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link), .sw_in(sw_q),
    .enable_n_in(enable_n_q), .pwm_in(pwm_q), .speed_adc_in(meas_q), .brake_adc_in(brake_q),
    .motor_speed_in(meas_q), .motor_current_in(meas_q), .supply_level_in(meas_q),
    .cooler_temp_in(meas_q), .board_temp_in(meas_q), .over_temp_in(flag_q),
    .current_limiting_in(flag_q), .current_ceiling_pot_in(meas_q),
    .ramp_time_pot_in(meas_q), .braking_ceiling_pot_in(meas_q), .drive_en_out(drive_en),
    .speed_demand_out(demand), .rotation_out(rot), .brake_active_out(brake_act),
    .brake_force_out(brk_force), .current_ceiling_out(ceiling), .ramp_up_out(ramp_up),
    .ramp_down_out(), .peak_current_en_out(peak_en), .simple_proto_out(simple),
    .serial_mode_out(serial), .speed_source_out(src), .persist_flags_out(), .led_out(led));
  motor_link_properties i_motor_link_properties (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .host_to_dev(link.host_to_dev), .dev_to_host(link.dev_to_host));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_q <= a;
    wdata_q <= d;
    wr_q <= 1'b1;
    @(posedge ref_clk_in);
    wr_q <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr_q <= a;
    rd_q <= 1'b1;
    @(posedge ref_clk_in);
    rd_q <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic send_byte(input logic [7:0] b);
    int n;
    n = 0;
    reg_wr(`HREG_TX, b);
    got = 8'h01;
    while (got[0] === 1'b1 && n < 6 * BIT)
    begin
      reg_rd(`HREG_STAT, got);
      n++;
    end
    cmp({7'h00, got[0]}, 8'h00);
  endtask
  task automatic recv_byte(input logic [7:0] e);
    int n;
    n = 0;
    got = 8'h00;
    while (got[1] !== 1'b1 && n < 7 * BIT)
    begin
      reg_rd(`HREG_STAT, got);
      n++;
    end
    reg_rd(`HREG_RX, got);
    cmp(got, e);
  endtask
  always @(posedge ref_clk_in)
  begin
    cycles++;
    // 2.5 ms period, 2000 us high: fits both duty and radio pulse decoding
    pwm_q <= cycles % 25000 < 20000;
    if (cycles == 115000)
    begin
      fail_count++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (25) @(posedge ref_clk_in);
    cmp({7'h00, led}, 8'h01);
    repeat (50) @(posedge ref_clk_in);
    cmp({7'h00, led}, 8'h00);
    repeat (150) @(posedge ref_clk_in);
    cmp({7'h00, led}, 8'h01);
    cmp({7'h00, drive_en}, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      sw_q <= {1'b0, 1'b1, i[0], i[0], i[1]};
      repeat (5) @(posedge ref_clk_in);
      cmp({6'h00, src}, {6'h00, i[1:0]});
      cmp({7'h00, peak_en}, {7'h00, i[0]});
    end
    sw_q <= 5'h00;
    brake_q <= `BRAKE_ON_LEVEL;
    repeat (5) @(posedge ref_clk_in);
    cmp({7'h00, simple}, 8'h00);
    cmp({7'h00, brake_act}, 8'h00);
    brake_q <= `BRAKE_ON_LEVEL + 7'h01;
    repeat (5) @(posedge ref_clk_in);
    cmp({7'h00, brake_act}, 8'h01);
    cmp({1'b0, brk_force}, {1'b0, meas_q});
    sw_q <= 5'h08;
    enable_n_q <= 1'b0;
    brake_q <= 7'h00;
    $display("test pins done");
    send_byte(`CMD_MODE_AUTO);
    cmp({7'h00, serial}, 8'h01);
    cmp({6'h00, rot}, {6'h00, `DIR_STOP});
    cmp({1'b0, ramp_up}, 8'h00);
    send_byte(`CMD_DIR);
    send_byte({6'h00, `DIR_FWD});
    cmp({6'h00, rot}, {6'h00, `DIR_FWD});
    cmp({7'h00, drive_en}, 8'h00);
    send_byte(8'h82);
    send_byte(8'h05);
    cmp({1'b0, ceiling}, 8'h05);
    cmp({7'h00, drive_en}, 8'h01);
    send_byte(8'hC2);
    recv_byte(8'h05);
    send_byte(8'h81);
    cmp({7'h00, link.dev_to_host}, 8'h01);
    // autostop has run out by now, long after the last mode command
    cmp({7'h00, drive_en}, 8'h00);
    send_byte(`CMD_MODE_FREE);
    cmp({7'h00, drive_en}, 8'h01);
    send_byte(`CMD_MODE_OFF);
    cmp({7'h00, serial}, 8'h00);
    cmp({1'b0, ramp_up}, {1'b0, meas_q});
    @(posedge ref_clk_in);
    sw_q <= 5'h1B;
    repeat (5) @(posedge ref_clk_in);
    cmp({1'b0, demand}, 8'h3D);
    cmp({7'h00, brake_act}, 8'h01);
    cmp({1'b0, brk_force}, {1'b0, meas_q});
    sw_q <= 5'h19;
    repeat (5) @(posedge ref_clk_in);
    cmp({1'b0, demand}, 8'h66);
    $display("test serial done");
    report_and_stop;
  end
endmodule
